// ==== logic/fpt_device.sv ====
`default_nettype none
// flash end: parameter table, power-on gating, write latch, soft reset
module fpt_device
    import fpt_pkg::*;
#(
    parameter int READ_CYC = READ_DELAY_CYC,
    parameter int WRITE_CYC = WRITE_DELAY_CYC
)
(
    input wire logic mclk,
    input wire logic rst, // power-on reset, high while below threshold
    input wire logic [1:0] lineMode, // host-selected line mode
    fpt_link_if.device link,
    output logic writeLatchFlag, // write_latch_flag
    output logic deepDown, // deep power-down state
    output logic readReady, // read_access_delay elapsed
    output logic writeReady, // write_access_delay elapsed
    output logic resetPulse // one-cycle soft reset
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        FPT_IDLE = 3'b000,
        FPT_OPCODE = 3'b001,
        FPT_ADDR = 3'b010,
        FPT_DUMMY = 3'b011,
        FPT_DATA = 3'b100,
        FPT_SKIP = 3'b101
    } fpt_dstate_e;
    typedef struct packed {
        logic [1:0] sckS; // sck synchroniser
        logic [1:0] csS; // select synchroniser
        logic [7:0] io0S; // 2 stages x 4 lines
        logic sckQ; // previous synced clock
        fpt_dstate_e st;
        logic [23:0] shift; // opcode/address collect
        logic [5:0] bits; // bits gathered
        logic [7:0] addr;
        logic [7:0] txByte;
        logic [3:0] dout;
        logic [3:0] oeN;
        logic armed; // reset enable seen just before
        logic write_latch_flag;
        logic down;
        logic [31:0] rcnt;
        logic [31:0] wcnt;
        logic rstP;
    } fpt_dev_s;
    fpt_dev_s s_r, s_nxt;
    logic [3:0] ioSync;
    logic sckRise, sckFall, csHigh;
    logic [3:0] bpc; // bits per clock
    logic [5:0] need;
    logic [23:0] shifted;
    assign ioSync = s_r.io0S[7:4];
    assign csHigh = s_r.csS[1];
    assign sckRise = s_r.sckS[1] && !s_r.sckQ;
    assign sckFall = !s_r.sckS[1] && s_r.sckQ;
    // byte lookup with blank fill
    function automatic logic [7:0] tbl_byte(input logic [7:0] a);
        logic [31:0] w;
        w = TBL_WORD3;
        if (a < TBL_BASE || a > TBL_LAST)
            return TBL_BLANK; // [RULE_11]
        unique case (a[3:2])
            2'd0: w = TBL_WORD0; // [RULE_01] [RULE_02]
            2'd1: w = TBL_WORD1; // [RULE_03] [RULE_04] [RULE_05] [RULE_06] [RULE_07]
            2'd2: w = TBL_WORD2; // [RULE_08] [RULE_09] [RULE_10]
            2'd3: w = TBL_WORD3; // [RULE_11]
        endcase
        return w[8*a[1:0] +: 8]; // [RULE_19]
    endfunction
    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rstP = 1'b0;
        s_nxt.sckS = {s_r.sckS[0], link.sck};
        s_nxt.csS = {s_r.csS[0], link.csN};
        s_nxt.io0S = {s_r.io0S[3:0], link.io};
        s_nxt.sckQ = s_r.sckS[1];
        unique case (lineMode)
            FPT_DUAL: bpc = 4'd2;
            FPT_QUAD: bpc = 4'd4;
            default: bpc = 4'd1;
        endcase
        need = 6'd8;
        shifted = s_r.shift;
        // power-on delay counters
        if (s_r.rcnt < 32'(READ_CYC))
            s_nxt.rcnt = s_r.rcnt + 32'd1;
        if (s_r.wcnt < 32'(WRITE_CYC))
            s_nxt.wcnt = s_r.wcnt + 32'd1;
        if (csHigh || s_r.rcnt < 32'(READ_CYC)) // [RULE_17] [RULE_18]
        begin
            s_nxt.st = FPT_IDLE;
            s_nxt.oeN = 4'hF;
            s_nxt.bits = 6'd0;
            s_nxt.shift = 24'd0;
        end
        else
        begin
            if (s_r.st == FPT_IDLE)
                s_nxt.st = FPT_OPCODE;
            if (sckRise && s_r.st != FPT_DATA && s_r.st != FPT_SKIP)
            begin
                // sample lines, line 0 only in single mode
                unique case (bpc)
                    4'd2: shifted = {s_r.shift[21:0], ioSync[1:0]};
                    4'd4: shifted = {s_r.shift[19:0], ioSync};
                    default: shifted = {s_r.shift[22:0], ioSync[0]};
                endcase
                s_nxt.shift = shifted;
                s_nxt.bits = s_r.bits + 6'(bpc);
                if (s_r.st == FPT_ADDR)
                    need = 6'd24;
                if (s_r.st == FPT_DUMMY)
                    need = 6'(TBL_DUMMY); // [RULE_12]
                if (s_r.st == FPT_DUMMY ? (s_r.bits + 6'd1 >= need)
                    : (s_r.bits + 6'(bpc) >= need))
                begin
                    s_nxt.bits = 6'd0;
                    s_nxt.shift = 24'd0;
                    unique case (s_r.st)
                        FPT_OPCODE:
                        begin
                            s_nxt.st = FPT_SKIP;
                            s_nxt.armed = 1'b0;
                            if (s_r.down && shifted[7:0] != OP_RELEASE_DOWN)
                                s_nxt.st = FPT_SKIP; // ignored while powered down
                            else if (shifted[7:0] == OP_TABLE_READ && lineMode != 2'b11)
                                s_nxt.st = FPT_ADDR; // [RULE_13]
                            else if (shifted[7:0] == OP_RESET_EN)
                                s_nxt.armed = 1'b1;
                            else if (shifted[7:0] == OP_RESET && s_r.armed)
                            begin
                                s_nxt.rstP = 1'b1; // [RULE_04]
                                s_nxt.write_latch_flag = 1'b0;
                            end
                            else if (shifted[7:0] == OP_POWER_DOWN)
                                s_nxt.down = 1'b1;
                            else if (shifted[7:0] == OP_RELEASE_DOWN)
                                s_nxt.down = 1'b0;
                            else if (shifted[7:0] == OP_CLR_WRITE_LATCH)
                                s_nxt.write_latch_flag = 1'b0;
                            else if (shifted[7:0] == OP_SET_WRITE_LATCH
                                && s_r.wcnt >= 32'(WRITE_CYC))
                                s_nxt.write_latch_flag = 1'b1; // [RULE_16]
                        end
                        FPT_ADDR:
                        begin
                            s_nxt.addr = shifted[7:0];
                            s_nxt.st = FPT_DUMMY;
                        end
                        default:
                        begin
                            s_nxt.st = FPT_DATA;
                            s_nxt.txByte = tbl_byte(s_r.addr);
                            s_nxt.bits = 6'd0;
                        end
                    endcase
                end
                else if (s_r.st == FPT_DUMMY)
                    s_nxt.bits = s_r.bits + 6'd1;
            end
            if (sckFall && s_r.st == FPT_DATA)
            begin
                // drive out msb first, then advance to next byte
                s_nxt.oeN = (bpc == 4'd4) ? 4'h0 : (bpc == 4'd2 ? 4'hC : 4'hD);
                unique case (bpc)
                    4'd2: s_nxt.dout = {2'b00, s_r.txByte[7:6]};
                    4'd4: s_nxt.dout = s_r.txByte[7:4];
                    default: s_nxt.dout = {2'b00, s_r.txByte[7], 1'b0};
                endcase
                s_nxt.txByte = {s_r.txByte[7 - 0 -: 8] << bpc};
                s_nxt.bits = s_r.bits + 6'(bpc);
                if (s_r.bits + 6'(bpc) >= 6'd8)
                begin
                    s_nxt.bits = 6'd0;
                    s_nxt.addr = s_r.addr + 8'd1; // [RULE_19]
                    s_nxt.txByte = tbl_byte(s_r.addr + 8'd1);
                end
            end
        end
    end
    // ****************************************
    // registers; reset holds all while below threshold
    // ****************************************
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0; // [RULE_14] [RULE_15]
            s_r.csS <= 2'b11;
            s_r.oeN <= 4'hF;
            s_r.st <= FPT_IDLE;
        end
        else
            s_r <= s_nxt;
    end
    assign link.devDout = s_r.dout;
    assign link.devOeN = s_r.oeN;
    assign writeLatchFlag = s_r.write_latch_flag;
    assign deepDown = s_r.down;
    assign readReady = (s_r.rcnt >= 32'(READ_CYC));
    assign writeReady = (s_r.wcnt >= 32'(WRITE_CYC));
    assign resetPulse = s_r.rstP;
endmodule : fpt_device
`default_nettype wire

// ==== logic/fpt_host.sv ====
`default_nettype none
// host end: waits out power-up, then sends one command on request
module fpt_host
    import fpt_pkg::*;
#(
    parameter int READ_CYC = READ_DELAY_CYC,
    parameter int WRITE_CYC = WRITE_DELAY_CYC
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] lineMode,
    input wire logic cmdValid, // start a command
    input wire logic [7:0] cmdOp,
    input wire logic cmdHasAddr, // send address and dummy, read one byte
    input wire logic [7:0] cmdAddr,
    output logic cmdReady,
    output logic rdValid, // one-cycle pulse
    output logic [7:0] rdData,
    fpt_link_if.host link
);
    typedef enum logic [1:0] {
        FPH_WAIT = 2'b00,
        FPH_IDLE = 2'b01,
        FPH_SHIFT = 2'b10,
        FPH_DONE = 2'b11
    } fpt_hstate_e;
    typedef struct packed {
        fpt_hstate_e st;
        logic [31:0] pcnt; // power-up wait
        logic [39:0] sh; // op, addr(24), dummy bits
        logic [6:0] clks; // host clocks left
        logic [6:0] rxStart; // clock index where data begins
        logic [1:0] div;
        logic sck;
        logic csN;
        logic [7:0] rx;
        logic [7:0] data;
        logic valid;
        logic [3:0] oeN;
    } fpt_host_s;
    fpt_host_s h_r, h_nxt;
    logic [3:0] inS1_r, inS2_r; // io synchroniser
    logic [2:0] bpc;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            inS1_r <= 4'h0;
            inS2_r <= 4'h0;
        end
        else
        begin
            inS1_r <= link.io;
            inS2_r <= inS1_r;
        end
    end
    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        h_nxt = h_r;
        h_nxt.valid = 1'b0;
        bpc = (lineMode == FPT_QUAD) ? 3'd4 : (lineMode == FPT_DUAL ? 3'd2 : 3'd1);
        unique case (h_r.st)
            FPH_WAIT:
            begin
                // select held off through power-up
                h_nxt.pcnt = h_r.pcnt + 32'd1; // [RULE_18]
                if (h_r.pcnt >= 32'(WRITE_CYC) && h_r.pcnt >= 32'(READ_CYC))
                    h_nxt.st = FPH_IDLE; // [RULE_16]
            end
            FPH_IDLE:
            begin
                if (cmdValid)
                begin
                    h_nxt.st = FPH_SHIFT;
                    h_nxt.csN = 1'b0;
                    h_nxt.sh = {cmdOp, 16'h0000, cmdAddr, 8'h00};
                    h_nxt.clks = cmdHasAddr ? 7'(32 / bpc + TBL_DUMMY + 8 / bpc) // [RULE_12]
                        : 7'(8 / bpc);
                    h_nxt.rxStart = 7'(8 / bpc);
                    h_nxt.oeN = (bpc == 3'd4) ? 4'h0 : (bpc == 3'd2 ? 4'hC : 4'hE); // [RULE_13]
                    h_nxt.div = 2'd0;
                end
            end
            FPH_SHIFT:
            begin
                h_nxt.div = h_r.div + 2'd1;
                if (h_r.div == 2'(SCK_HALF - 1))
                begin
                    h_nxt.div = 2'd0;
                    h_nxt.sck = !h_r.sck;
                    if (h_r.sck)
                    begin
                        // falling edge: shift next bits, or finish
                        h_nxt.clks = h_r.clks - 7'd1;
                        h_nxt.sh = h_r.sh << bpc;
                        // let go of the lines as the last dummy clock ends;
                        // an opcode-only frame is never that long, so it keeps them
                        if (h_r.clks == h_r.rxStart + 7'd1)
                            h_nxt.oeN = 4'hF;
                        // data phase: sample at the end of the clock, since the
                        // answer needs several cycles to come back through syncs
                        if (h_r.clks <= h_r.rxStart && h_r.oeN == 4'hF)
                        begin
                            unique case (bpc)
                                3'd4: h_nxt.rx = {h_r.rx[3:0], inS2_r};
                                3'd2: h_nxt.rx = {h_r.rx[5:0], inS2_r[1:0]};
                                default: h_nxt.rx = {h_r.rx[6:0], inS2_r[1]};
                            endcase
                        end
                        if (h_r.clks == 7'd1)
                            h_nxt.st = FPH_DONE;
                    end
                end
            end
            FPH_DONE:
            begin
                h_nxt.csN = 1'b1;
                h_nxt.st = FPH_IDLE;
                h_nxt.data = h_r.rx;
                h_nxt.valid = (h_r.oeN == 4'hF);
                h_nxt.oeN = 4'hF;
            end
        endcase
    end
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            h_r <= '0;
            h_r.csN <= 1'b1;
            h_r.oeN <= 4'hF;
            h_r.st <= FPH_WAIT;
        end
        else
            h_r <= h_nxt;
    end
    assign link.sck = h_r.sck;
    assign link.csN = h_r.csN;
    assign link.hostOeN = h_r.oeN;
    assign link.hostDout = (bpc == 3'd4) ? h_r.sh[39:36]
        : (bpc == 3'd2 ? {2'b00, h_r.sh[39:38]} : {3'b000, h_r.sh[39]});
    assign cmdReady = (h_r.st == FPH_IDLE);
    assign rdValid = h_r.valid;
    assign rdData = h_r.data;
endmodule : fpt_host
`default_nettype wire

// ==== logic/fpt_link_if.sv ====
`default_nettype none
// serial link: host drives clock and select, four data lines both ways
interface fpt_link_if;
    logic sck; // serial clock from host
    logic csN; // chip select, low active
    logic [3:0] hostDout; // host data out
    logic [3:0] hostOeN; // host enables, low drives
    logic [3:0] devDout; // device data out
    logic [3:0] devOeN; // device enables, low drives
    logic [3:0] io; // resolved line levels
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            io[i] = !hostOeN[i] ? hostDout[i] : (!devOeN[i] ? devDout[i] : 1'b1);
        end
    end
    modport device (input sck, input csN, input io, output devDout, output devOeN);
    modport host (output sck, output csN, output hostDout, output hostOeN, input io);
endinterface : fpt_link_if
`default_nettype wire

// ==== logic/fpt_pkg.sv ====
// Operation
// [RULE_01] max supply code 2000h at 60h-61h
// [RULE_02] min supply code 1650h at 62h-63h
// [RULE_03] no reset/hold pins, deep powerdown, soft reset
// [RULE_04] reset opcode 99h, needs 66h first
// [RULE_05] program and erase suspend supported bits
// [RULE_06] wrap read bit, opcode C0h at 66h
// [RULE_07] wrap length code 64h at 67h
// [RULE_08] block lock supported, volatile, opcode 36h
// [RULE_09] lock bits default to protected
// [RULE_10] otp supported, no read/permanent lock
// [RULE_11] unused table bytes read FFh
// [RULE_12] host sends mode bits then dummy clocks
// [RULE_13] table read only in 1-1-1/2-2-2/4-4-4
// [RULE_14] power-up in standby, write latch clear
// [RULE_15] below threshold: reset, ignore commands
// [RULE_16] write commands wait for both delays
// [RULE_17] reads allowed after read delay alone
// [RULE_18] host keeps select off during power-up
// [RULE_19] sequential bytes, words little endian
`default_nettype none
package fpt_pkg;
    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OP_TABLE_READ = 8'h5A; // parameter-table read
    localparam logic [7:0] OP_RESET_EN = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h38;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
    localparam logic [7:0] OP_SECURITY_REG_WRITE = 8'h2F;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
    localparam logic [7:0] OP_RELEASE_DOWN = 8'hAB;
    // ****************************************
    // table contents, bytes 60h..6Fh
    // ****************************************
    localparam logic [7:0] TBL_BASE = 8'h60;
    localparam logic [7:0] TBL_LAST = 8'h6F;
    localparam logic [7:0] TBL_BLANK = 8'hFF;
    localparam logic [31:0] TBL_WORD0 = 32'h1650_2000; // supply limits
    localparam logic [31:0] TBL_WORD1 = 32'h64C0_F99C; // reset, suspend, wrap
    localparam logic [31:0] TBL_WORD2 = 32'hFFFF_C8D9; // block lock, otp
    localparam logic [31:0] TBL_WORD3 = 32'hFFFF_FFFF; // unused
    localparam int TBL_DUMMY = 8; // dummy clocks after address
    // ****************************************
    // line modes and timing
    // ****************************************
    typedef enum logic [1:0] {
        FPT_SINGLE = 2'b00,
        FPT_DUAL = 2'b01,
        FPT_QUAD = 2'b10
    } fpt_lines_e;
    localparam int CLK_NS = 25;
    localparam int READ_DELAY_US = 800; // read_access_delay
    localparam int WRITE_DELAY_US = 5000; // write_access_delay
    localparam int READ_DELAY_CYC = (READ_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_DELAY_CYC = (WRITE_DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;
    // host clock half period in mclk; the answer crosses two synchronisers each way,
    // so anything shorter than three cycles lets the host sample before it arrives
    localparam int SCK_HALF = 4;
endpackage : fpt_pkg
`default_nettype wire

// ==== verification/fpt_link_asserts.sv ====
`default_nettype none
// ****************************************
// link checker: wire rules between both ends
// ****************************************
module fpt_link_asserts
    import fpt_pkg::*;
#(
    parameter int READ_CYC = READ_DELAY_CYC
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] lineMode,
    input wire logic sck,
    input wire logic csN,
    input wire logic [3:0] hostOeN,
    input wire logic [3:0] devOeN
);
    timeunit 1ns;
    timeprecision 100ps;
    // cycles since reset release, saturating so it never wraps
    int upCnt_r;
    // count the power-up window
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            upCnt_r <= 0;
        else if (upCnt_r < READ_CYC)
            upCnt_r <= upCnt_r + 1;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    chk_select_held_off: assert property (upCnt_r < READ_CYC |-> csN)
        else $error("select asserted during power-up");
    chk_dev_quiet_powerup: assert property (upCnt_r < READ_CYC |-> &devOeN)
        else $error("device drove a line during power-up");
    // four cycles of grace for the device's select synchroniser
    chk_dev_off_deselect: assert property (csN && $past(csN, 4) |-> &devOeN)
        else $error("device drove a line while deselected");
    chk_no_contention: assert property (&(hostOeN | devOeN))
        else $error("both ends drove the same line");
    chk_single_lines: assert property (!csN && lineMode == 2'h0 |->
        hostOeN[1] && devOeN[0] && &devOeN[3:2])
        else $error("wrong lines used in single mode");
    chk_dual_lines: assert property (!csN && lineMode == 2'h1 |->
        &hostOeN[3:2] && &devOeN[3:2])
        else $error("upper lines used in dual mode");
    chk_mode_illegal: assert property (lineMode == 2'h3 |-> &devOeN)
        else $error("device answered in the illegal mode");
    chk_sck_idle_low: assert property (csN && $past(csN) |-> !sck)
        else $error("serial clock moved outside a frame");
    // even a quad opcode needs two serial clocks, so eight cycles at least
    chk_frame_min_len: assert property ($fell(csN) |=> !csN [*7])
        else $error("frame shorter than one opcode");
endmodule // fpt_link_asserts
`default_nettype wire

// ==== verification/fpt_test.sv ====
`default_nettype none
`define CHECK_EQ(act, exp) begin numChecks++; if ((act) !== (exp)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, act, exp); end end
// ****************************************
// bench: host and device face each other
// ****************************************
module fpt_test
    import fpt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DEV_READ = 50; // short delays keep the run brief
    // long enough that the early write below still falls inside it
    localparam int DEV_WRITE = 1000;
    localparam int LIM = 5000; // bound on any wait
    typedef struct packed {logic [1:0] m; logic [7:0] a; logic [7:0] d;} fpt_row_s;
    // line mode, table address, expected byte
    fpt_row_s rows [16] = '{
        '{2'h0, 8'h60, 8'h00}, '{2'h1, 8'h61, 8'h20},
        '{2'h2, 8'h62, 8'h50}, '{2'h0, 8'h63, 8'h16},
        '{2'h1, 8'h64, 8'h9C}, '{2'h2, 8'h65, 8'hF9},
        '{2'h0, 8'h66, 8'hC0}, '{2'h1, 8'h67, 8'h64},
        '{2'h2, 8'h68, 8'hD9}, '{2'h0, 8'h69, 8'hC8},
        '{2'h1, 8'h6A, 8'hFF}, '{2'h2, 8'h6B, 8'hFF},
        '{2'h0, 8'h6C, 8'hFF}, '{2'h1, 8'h6D, 8'hFF},
        '{2'h2, 8'h6E, 8'hFF}, '{2'h0, 8'h6F, 8'hFF}};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] lineMode = 2'h0;
    logic cmdValid = 1'b0;
    logic [7:0] cmdOp = 8'h00;
    logic cmdHasAddr = 1'b0;
    logic [7:0] cmdAddr = 8'h00;
    logic cmdReady, rdValid, writeLatchFlag, deepDown, readReady, writeReady, resetPulse;
    logic [7:0] rdData;
    logic [7:0] got;
    logic devDrove = 1'b0; // device enabled any line since last clear
    int mismatches = 0;
    int numChecks = 0;
    int pulses = 0; // soft reset pulses seen
    fpt_link_if fpt_link_if_i ();
    fpt_device #(.READ_CYC(DEV_READ), .WRITE_CYC(DEV_WRITE)) fpt_device_i (.mclk(mclk),
        .rst(rst), .lineMode(lineMode), .link(fpt_link_if_i), .writeLatchFlag(writeLatchFlag),
        .deepDown(deepDown), .readReady(readReady), .writeReady(writeReady),
        .resetPulse(resetPulse));
    // host waits only the read delay, so writes can be tried too early
    fpt_host #(.READ_CYC(DEV_READ), .WRITE_CYC(DEV_READ)) fpt_host_i (.mclk(mclk), .rst(rst),
        .lineMode(lineMode), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdHasAddr(cmdHasAddr),
        .cmdAddr(cmdAddr), .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData),
        .link(fpt_link_if_i));
    fpt_link_asserts #(.READ_CYC(DEV_READ)) fpt_link_asserts_i (.mclk(mclk), .rst(rst),
        .lineMode(lineMode), .sck(fpt_link_if_i.sck), .csN(fpt_link_if_i.csN),
        .hostOeN(fpt_link_if_i.hostOeN), .devOeN(fpt_link_if_i.devOeN));
    // 40 MHz clock
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end
    // soft reset pulses and any device drive
    always @(posedge mclk)
    begin
        if (resetPulse === 1'b1) pulses++;
        if (fpt_link_if_i.devOeN !== 4'hF) devDrove = 1'b1;
    end
    // ****************************************
    // tasks
    // ****************************************
    // closing report, the only exit
    task automatic printVerdict();
        $display("checks %0d, mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one command; d holds the byte if the host returned one
    task automatic issue(input logic [1:0] m, input logic [7:0] op, input logic ha,
        input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        d = 8'hXX;
        while (cmdReady !== 1'b1 && n < LIM)
        begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        lineMode <= m;
        cmdOp <= op;
        cmdHasAddr <= ha;
        cmdAddr <= a;
        cmdValid <= 1'b1;
        @(posedge mclk);
        cmdValid <= 1'b0;
        n = 0;
        // idle plus eight cycles, since the device acts after its synchroniser
        for (int k = 0; k < LIM && n < 8; k++)
        begin
            @(negedge mclk);
            if (rdValid === 1'b1) d = rdData;
            if (cmdReady === 1'b1) n++;
        end
        if (n < 8)
        begin
            mismatches++;
            $display("Error at %0t: host never returned to idle", $time);
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (16) @(posedge mclk);
        `CHECK_EQ(writeLatchFlag, 1'b0)
        `CHECK_EQ(deepDown, 1'b0)
        `CHECK_EQ(readReady, 1'b0)
        rst <= 1'b0;
        // reads work before the write delay is over, writes do not
        issue(2'h0, OP_TABLE_READ, 1'b1, 8'h61, got);
        `CHECK_EQ(got, 8'h20)
        `CHECK_EQ(readReady, 1'b1)
        `CHECK_EQ(writeReady, 1'b0)
        issue(2'h0, OP_SET_WRITE_LATCH, 1'b0, 8'h00, got);
        `CHECK_EQ(writeLatchFlag, 1'b0)
        foreach (rows[i])
        begin
            issue(rows[i].m, OP_TABLE_READ, 1'b1, rows[i].a, got);
            `CHECK_EQ(got, rows[i].d)
        end
        // illegal line mode: device must stay silent, lines float high
        devDrove = 1'b0;
        issue(2'h3, OP_TABLE_READ, 1'b1, 8'h60, got);
        `CHECK_EQ(devDrove, 1'b0)
        `CHECK_EQ(got, 8'hFF)
        // reset opcode alone is refused, the enabled pair fires once
        issue(2'h0, OP_RESET, 1'b0, 8'h00, got);
        `CHECK_EQ(pulses, 0)
        issue(2'h0, OP_RESET_EN, 1'b0, 8'h00, got);
        issue(2'h0, OP_RESET, 1'b0, 8'h00, got);
        `CHECK_EQ(pulses, 1)
        for (int n = 0; n < LIM && writeReady !== 1'b1; n++) @(negedge mclk);
        `CHECK_EQ(writeReady, 1'b1)
        issue(2'h0, OP_SET_WRITE_LATCH, 1'b0, 8'h00, got);
        `CHECK_EQ(writeLatchFlag, 1'b1)
        // deep power-down refuses table reads until released
        issue(2'h0, OP_POWER_DOWN, 1'b0, 8'h00, got);
        `CHECK_EQ(deepDown, 1'b1)
        devDrove = 1'b0;
        issue(2'h0, OP_TABLE_READ, 1'b1, 8'h60, got);
        `CHECK_EQ(devDrove, 1'b0)
        `CHECK_EQ(got, 8'hFF)
        issue(2'h0, OP_RELEASE_DOWN, 1'b0, 8'h00, got);
        `CHECK_EQ(deepDown, 1'b0)
        // supply dip in mid-run clears the latch and closes the gates
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(negedge mclk);
        `CHECK_EQ(writeLatchFlag, 1'b0)
        `CHECK_EQ(readReady, 1'b0)
        @(posedge mclk);
        rst <= 1'b0;
        issue(2'h2, OP_TABLE_READ, 1'b1, 8'h6C, got);
        `CHECK_EQ(got, 8'hFF)
        printVerdict();
    end
    // watchdog, well beyond the expected run
    initial
    begin
        #(40000 * 25);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        printVerdict();
    end
endmodule // fpt_test
`default_nettype wire
